//--- design/rxb_pkg.sv
// constants shared by the receive error counter and self-test control block
package rxb_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [4:0] ADDR_PHY_CTRL  = 5'h11;
    localparam logic [4:0] ADDR_INT_CTRL  = 5'h12;
    localparam logic [4:0] ADDR_RX_ERR    = 5'h15;
    localparam logic [4:0] ADDR_SELF_TEST = 5'h16;
    localparam logic [4:0] ADDR_PRBS_ERR  = 5'h1b;

    // phy_specific_control fields
    localparam int PSC_INT_OUT_EN_BIT = 0;
    localparam int PSC_INT_EN_BIT     = 1;

    // interrupt control fields
    localparam int INT_RX_ERR_HALF_FULL_ENABLE_BIT   = 0;
    localparam int INT_RE_HF_PEND_BIT = 8;

    // self_test_control fields
    localparam int STC_WRAP_BIT     = 14;
    localparam int STC_PAYLOAD_BIT  = 13;
    localparam int STC_GEN_EN_BIT   = 12;
    localparam int STC_LOCK_BIT     = 11;
    localparam int STC_LOSS_BIT     = 10;
    localparam int STC_GEN_STAT_BIT = 9;
    localparam int STC_POWER_BIT    = 8;

    // receive error counter limits and reset values
    localparam logic [15:0] RX_ERR_MAX   = 16'hffff;
    localparam logic [15:0] RX_ERR_HALF  = 16'h7fff;
    localparam logic [15:0] RX_ERR_RST   = 16'h0000;
    localparam logic [15:0] DATA_ZERO    = 16'h0000;
    localparam logic        CTRL_RST     = 1'b0;

    // prbs engine defaults
    localparam logic [14:0] PRBS_SEED    = 15'h7fff;
    localparam logic [7:0]  CONST_BYTE   = 8'ha5;
    localparam int          PKT_BITS_DEF = 512;
    localparam int          GAP_BITS_DEF = 96;
    localparam int          LOCK_RUN_DEF = 32;
    localparam int          LOSS_RUN_DEF = 4;
    localparam int          ERR_W_DEF    = 16;

endpackage

//--- design/rxb_prbs_engine.sv
// prbs packet generator and checker with its error counter
`timescale 1ns/10ps

module rxb_prbs_engine
    import rxb_pkg::*;
#(
    parameter int PKT_BITS = PKT_BITS_DEF,
    parameter int GAP_BITS = GAP_BITS_DEF,
    parameter int LOCK_RUN = LOCK_RUN_DEF,
    parameter int LOSS_RUN = LOSS_RUN_DEF,
    parameter int ERR_W    = ERR_W_DEF
)
(
    input  wire logic             mclk,          // system clock
    input  wire logic             reset,         // synchronous reset
    input  wire logic             genEnable,     // packet generation enable
    input  wire logic             payloadSel,    // 1 prbs packets, 0 one constant packet
    input  wire logic             wrapSel,       // 1 error counter wraps, 0 stops
    input  wire logic             errClear,      // clear error count (read side effect)
    input  wire logic             rxBit,         // received bit
    input  wire logic             rxBitValid,    // received bit qualifier
    output logic                  txBit,         // generated bit
    output logic                  txBitValid,    // generated bit qualifier
    output logic                  genActive,     // generator producing packets
    output logic                  locked,        // checker in sync
    output logic                  syncLossPulse, // one cycle on loss of sync
    output logic                  errWrapPulse,  // one cycle when counter wraps
    output logic [ERR_W-1:0]      errCount       // checker error count
);

    typedef enum logic [1:0] {GEN_IDLE, GEN_SEND, GEN_GAP, GEN_DONE} rxb_gen_t;

    if (PKT_BITS < 8 || PKT_BITS > 65535 || GAP_BITS < 1 || GAP_BITS > 65535 ||
        LOCK_RUN < 16 || LOCK_RUN > 255 || LOSS_RUN < 1 || LOSS_RUN > 255 || ERR_W < 2)
    begin : g_bad_params
        $error("rxb_prbs_engine: parameter out of range");
    end

    localparam logic [15:0]      PKT_LAST  = 16'(PKT_BITS - 1);
    localparam logic [15:0]      GAP_LAST  = 16'(GAP_BITS - 1);
    localparam logic [7:0]       LOCK_LAST = 8'(LOCK_RUN - 1);
    localparam logic [7:0]       LOSS_LAST = 8'(LOSS_RUN - 1);
    localparam logic [ERR_W-1:0] ERR_MAX   = '1;

    rxb_gen_t          genState;
    rxb_gen_t          next_genState;
    logic [15:0]       bitCnt;
    logic [14:0]       genLfsr;
    logic [7:0]        constShift;
    logic [14:0]       chkHist;
    logic [7:0]        matchRun;
    logic [7:0]        missRun;

    wire               checkerOn  = payloadSel;
    wire               sending    = (genState == GEN_SEND);
    wire               genFb      = genLfsr[14] ^ genLfsr[13];
    wire               predicted  = chkHist[14] ^ chkHist[13];
    wire               rxMatch    = (rxBit == predicted);
    wire               checkBit   = checkerOn && rxBitValid;
    wire               badBit     = checkBit && locked && !rxMatch;
    wire [ERR_W-1:0]   errBase    = errClear ? '0 : errCount;
    wire               errAtMax   = (errBase == ERR_MAX);

    always_comb
    begin
        next_genState = genState;
        case (genState)
            GEN_IDLE:
                if (genEnable)
                    next_genState = GEN_SEND;
            GEN_SEND:
                if (!genEnable)
                    next_genState = GEN_IDLE;
                else if (bitCnt == PKT_LAST)
                    next_genState = payloadSel ? GEN_GAP : GEN_DONE;
            GEN_GAP:
                if (!genEnable)
                    next_genState = GEN_IDLE;
                else if (bitCnt == GAP_LAST)
                    next_genState = GEN_SEND;
            GEN_DONE:
                if (!genEnable)
                    next_genState = GEN_IDLE;
            default:
                next_genState = GEN_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            genState   <= GEN_IDLE;
            bitCnt     <= 16'h0000;
            genLfsr    <= PRBS_SEED;
            constShift <= CONST_BYTE;
            txBit      <= 1'b0;
            txBitValid <= 1'b0;
            genActive  <= 1'b0;
        end
        else
        begin
            genState   <= next_genState;
            bitCnt     <= (next_genState != genState) ? 16'h0000 : bitCnt + 16'h0001;
            txBitValid <= sending;
            txBit      <= payloadSel ? genLfsr[14] : constShift[7];
            genActive  <= (genState == GEN_SEND) || (genState == GEN_GAP);
            if (sending && payloadSel)
                genLfsr <= {genLfsr[13:0], genFb};
            if (sending)
                constShift <= {constShift[6:0], constShift[7]};
            if (genState == GEN_IDLE)
                constShift <= CONST_BYTE;
        end
    end

    // self-synchronising checker: history holds the last received bits
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            chkHist       <= 15'h0000;
            matchRun      <= 8'h00;
            missRun       <= 8'h00;
            locked        <= 1'b0;
            syncLossPulse <= 1'b0;
        end
        else
        begin
            syncLossPulse <= 1'b0;
            if (!checkerOn)
            begin
                locked   <= 1'b0;
                matchRun <= 8'h00;
                missRun  <= 8'h00;
            end
            else if (rxBitValid)
            begin
                chkHist <= {chkHist[13:0], rxBit};
                if (!locked)
                begin
                    matchRun <= rxMatch ? matchRun + 8'h01 : 8'h00;
                    if (rxMatch && matchRun == LOCK_LAST)
                        locked <= 1'b1;
                end
                else if (!rxMatch)
                begin
                    missRun <= missRun + 8'h01;
                    if (missRun == LOSS_LAST)
                    begin
                        locked        <= 1'b0;
                        syncLossPulse <= 1'b1;
                        matchRun      <= 8'h00;
                        missRun       <= 8'h00;
                    end
                end
                else
                    missRun <= 8'h00;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            errCount     <= '0;
            errWrapPulse <= 1'b0;
        end
        else
        begin
            errWrapPulse <= badBit && errAtMax && wrapSel;
            if (badBit && errAtMax)
                errCount <= wrapSel ? '0 : errBase;
            else if (badBit)
                errCount <= errBase + ERR_W'(1);
            else
                errCount <= errBase;
        end
    end

endmodule

//--- design/rxb_error_bist.sv
// receive error counter, interrupt gating and self-test control registers
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps

// Notes on behaviour
// - count one receive error per symbol error while data valid and carrier
// - no counting while mii loopback is active
// - receive error counter stops at ffff, never wraps
// - raise half-full event when count passes 7fff
// - reading the receive error counter returns count and clears it
// - half-full pending flag clears on read, enable gates only the interrupt
// - interrupt output needs both global interrupt control bits set
// - wrap mode: checker counter pulses at max and restarts at zero
// - single mode: checker error counter stops at its maximum
// - prbs payload: generator sends packets continuously, checker stays active
// - constant payload: generator sends one packet, prbs gen and check off
// - packet generation enable turns generator on or off, resets to zero
// - lock status bit shows checker synchronised
// - sync loss bit latches high when checker loses sync
// - generator status bit shows generator active
// - power mode bit is one in normal power, zero in sleep
// - self-test control bits 15 and 7 read zero, writes ignored
module rxb_error_bist
    import rxb_pkg::*;
#(
    parameter int PKT_BITS = PKT_BITS_DEF,
    parameter int GAP_BITS = GAP_BITS_DEF,
    parameter int LOCK_RUN = LOCK_RUN_DEF,
    parameter int LOSS_RUN = LOSS_RUN_DEF
)
(
    input  wire logic              mclk,          // 200 MHz clock
    input  wire logic              reset,         // synchronous, active high
    input  wire logic [ADDR_W-1:0] regAddr,       // register address
    input  wire logic [DATA_W-1:0] regWrData,     // register write data
    input  wire logic              regWrite,      // write strobe
    input  wire logic              regRead,       // read strobe
    output logic      [DATA_W-1:0] regRdData,     // read data, cycle after strobe
    input  wire logic              rxDataValid,   // receive data valid
    input  wire logic              rxCarrier,     // valid carrier present
    input  wire logic              rxSymbolError, // invalid data symbol this cycle
    input  wire logic              miiLoopback,   // mii loopback mode active
    input  wire logic              normalPower,   // 1 normal power, 0 sleep
    input  wire logic              rxBit,         // received bit for checker
    input  wire logic              rxBitValid,    // received bit qualifier
    output logic                   txBit,         // generated bit
    output logic                   txBitValid,    // generated bit qualifier
    output logic                   prbsErrWrap,   // checker counter wrap pulse
    output logic                   intOut         // interrupt, active high
);

    function automatic logic addrHit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] target);
        addrHit = (addr == target);
    endfunction

    logic [15:0]       rxErrCount;
    logic              rxErrHalfPending;
    logic              rxErrHalfEnable;
    logic              intGlobalEn;
    logic              intOutEn;
    logic              wrapSel;
    logic              payloadSel;
    logic              genEnable;
    logic              syncLost;
    logic              powerNormal;
    logic              genActive;
    logic              locked;
    logic              syncLossPulse;
    logic [15:0]       prbsErrCount;
    logic [15:0]       readWord;

    // address decode
    wire selPhyCtrl  = addrHit(regAddr, ADDR_PHY_CTRL);
    wire selIntCtrl  = addrHit(regAddr, ADDR_INT_CTRL);
    wire selRxErr    = addrHit(regAddr, ADDR_RX_ERR);
    wire selSelfTest = addrHit(regAddr, ADDR_SELF_TEST);
    wire selPrbsErr  = addrHit(regAddr, ADDR_PRBS_ERR);

    wire rdRxErr    = regRead && selRxErr;
    wire rdIntCtrl  = regRead && selIntCtrl;
    wire rdSelfTest = regRead && selSelfTest;
    wire rdPrbsErr  = regRead && selPrbsErr;
    wire wrPhyCtrl  = regWrite && selPhyCtrl;
    wire wrIntCtrl  = regWrite && selIntCtrl;
    wire wrSelfTest = regWrite && selSelfTest;

    // receive error counting; an error in the read cycle lands after the clear
    wire        rxErrEvent = rxDataValid && rxCarrier && rxSymbolError
                             && !miiLoopback;
    wire [15:0] rxErrBase  = rdRxErr ? RX_ERR_RST : rxErrCount;
    wire        rxErrInc   = rxErrEvent && (rxErrBase != RX_ERR_MAX);
    wire        halfEvent  = rxErrInc && (rxErrBase == RX_ERR_HALF);
    wire [15:0] next_rxErrCount  = rxErrInc ? rxErrBase + 16'h0001 : rxErrBase;
    wire        next_halfPending = halfEvent ||
                                   (rxErrHalfPending && !rdIntCtrl);
    wire        next_syncLost    = syncLossPulse ||
                                   (syncLost && !rdSelfTest);
    // global gate kept after the pending flag so status still records events
    wire        next_intOut      = rxErrHalfPending && rxErrHalfEnable
                                   && intGlobalEn && intOutEn;

    wire [15:0] phyCtrlWord  = {14'h0000, intGlobalEn, intOutEn};
    wire [15:0] intCtrlWord  = {7'h00, rxErrHalfPending, 7'h00, rxErrHalfEnable};
    // lower loopback bits are not part of this block and read as zero
    wire [15:0] selfTestWord = {1'b0,
                                wrapSel, payloadSel, genEnable,
                                locked,
                                syncLost,
                                genActive,
                                powerNormal,
                                8'h00};

    always_comb
    begin
        if (selPhyCtrl)
            readWord = phyCtrlWord;
        else if (selIntCtrl)
            readWord = intCtrlWord;
        else if (selRxErr)
            readWord = rxErrCount;
        else if (selSelfTest)
            readWord = selfTestWord;
        else if (selPrbsErr)
            readWord = prbsErrCount;
        else
            readWord = DATA_ZERO;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            regRdData <= DATA_ZERO;
        else
            regRdData <= regRead ? readWord : DATA_ZERO;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rxErrCount       <= RX_ERR_RST;
            rxErrHalfPending <= CTRL_RST;
            syncLost         <= CTRL_RST;
            intOut           <= CTRL_RST;
            powerNormal      <= CTRL_RST;
        end
        else
        begin
            rxErrCount       <= next_rxErrCount;
            rxErrHalfPending <= next_halfPending;
            syncLost         <= next_syncLost;
            intOut           <= next_intOut;
            powerNormal      <= normalPower;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            intGlobalEn     <= CTRL_RST;
            intOutEn        <= CTRL_RST;
            rxErrHalfEnable <= CTRL_RST;
            wrapSel         <= CTRL_RST;
            payloadSel      <= CTRL_RST;
            genEnable       <= CTRL_RST;
        end
        else
        begin
            if (wrPhyCtrl)
            begin
                intGlobalEn <= regWrData[PSC_INT_EN_BIT];
                intOutEn    <= regWrData[PSC_INT_OUT_EN_BIT];
            end
            if (wrIntCtrl)
                rxErrHalfEnable <= regWrData[INT_RX_ERR_HALF_FULL_ENABLE_BIT];
            if (wrSelfTest)
            begin
                wrapSel    <= regWrData[STC_WRAP_BIT];
                payloadSel <= regWrData[STC_PAYLOAD_BIT];
                genEnable  <= regWrData[STC_GEN_EN_BIT];
            end
        end
    end

    rxb_prbs_engine #(
        .PKT_BITS (PKT_BITS),
        .GAP_BITS (GAP_BITS),
        .LOCK_RUN (LOCK_RUN),
        .LOSS_RUN (LOSS_RUN),
        .ERR_W    (DATA_W)
    ) u_engine (
        .mclk          (mclk),
        .reset         (reset),
        .genEnable     (genEnable),
        .payloadSel    (payloadSel),
        .wrapSel       (wrapSel),
        .errClear      (rdPrbsErr),
        .rxBit         (rxBit),
        .rxBitValid    (rxBitValid),
        .txBit         (txBit),
        .txBitValid    (txBitValid),
        .genActive     (genActive),
        .locked        (locked),
        .syncLossPulse (syncLossPulse),
        .errWrapPulse  (prbsErrWrap),
        .errCount      (prbsErrCount)
    );

endmodule

//--- dv/rxb_error_bist_chk.sv
// port assertions for the receive error and self-test block
`timescale 1ns/10ps

module rxb_error_bist_chk
    import rxb_pkg::*;
(
    input wire logic              mclk,          // clock
    input wire logic              reset,         // sync reset
    input wire logic [ADDR_W-1:0] regAddr,       // address
    input wire logic [DATA_W-1:0] regWrData,     // write data
    input wire logic              regWrite,      // write strobe
    input wire logic              regRead,       // read strobe
    input wire logic [DATA_W-1:0] regRdData,     // read data
    input wire logic              rxDataValid,   // data valid
    input wire logic              rxCarrier,     // carrier
    input wire logic              rxSymbolError, // symbol error
    input wire logic              miiLoopback,   // loopback
    input wire logic              normalPower,   // power mode
    input wire logic              rxBit,         // rx bit
    input wire logic              rxBitValid,    // rx qualifier
    input wire logic              txBit,         // tx bit
    input wire logic              txBitValid,    // tx qualifier
    input wire logic              prbsErrWrap,   // wrap pulse
    input wire logic              intOut         // interrupt
);
    logic [1:0] pscBits;
    logic       hfEn;
    logic       genEn;
    logic       wrapEn;
    wire        errIn = rxDataValid && rxCarrier && rxSymbolError && !miiLoopback;
    wire        mappedAddr = (regAddr == ADDR_PHY_CTRL) || (regAddr == ADDR_INT_CTRL)
                || (regAddr == ADDR_RX_ERR) || (regAddr == ADDR_SELF_TEST)
                || (regAddr == ADDR_PRBS_ERR);

    // shadows of the writable enables, same timing as the registers
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pscBits <= 2'h0;
            hfEn    <= 1'b0;
            genEn   <= 1'b0;
            wrapEn  <= 1'b0;
        end
        else if (regWrite)
        begin
            if (regAddr == ADDR_PHY_CTRL) pscBits <= regWrData[1:0];
            if (regAddr == ADDR_INT_CTRL) hfEn <= regWrData[INT_RX_ERR_HALF_FULL_ENABLE_BIT];
            if (regAddr == ADDR_SELF_TEST) genEn <= regWrData[STC_GEN_EN_BIT];
            if (regAddr == ADDR_SELF_TEST) wrapEn <= regWrData[STC_WRAP_BIT];
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence s_rdErr;
        regRead && regAddr == ADDR_RX_ERR;
    endsequence

    a_rd_idle: assert property (
        !$past(regRead) |-> regRdData == DATA_ZERO) else $error("read data not idle");
    a_clear_back2back: assert property (
        s_rdErr ##1 s_rdErr |=> regRdData == {15'h0000, $past(errIn, 2)})
        else $error("count not cleared by read");
    a_int_needs_enable: assert property (
        intOut |-> $past(pscBits == 2'h3 && hfEn)) else $error("interrupt without enables");
    a_reserved_zero: assert property (
        $past(regRead) && $past(regAddr) == ADDR_SELF_TEST
        |-> regRdData[15] == 1'b0 && regRdData[7:0] == 8'h00)
        else $error("reserved bits not zero");
    a_unmapped_zero: assert property (
        $past(regRead) && !$past(mappedAddr) |-> regRdData == DATA_ZERO)
        else $error("unmapped read not zero");
    a_power_bit: assert property (
        $past(regRead) && $past(regAddr) == ADDR_SELF_TEST
        |-> regRdData[STC_POWER_BIT] == $past(normalPower, 2)) else $error("power bit wrong");
    a_gen_start: assert property (
        $rose(genEn) |-> ##[1:2] txBitValid) else $error("generator did not start");
    a_gen_off: assert property (
        !genEn [*3] |-> !txBitValid) else $error("generator runs while off");
    a_wrap_mode: assert property (
        prbsErrWrap |-> $past(wrapEn)) else $error("wrap pulse in single mode");
endmodule

bind rxb_error_bist rxb_error_bist_chk rxb_error_bist_chk_inst (
    .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .rxDataValid(rxDataValid), .rxCarrier(rxCarrier), .rxSymbolError(rxSymbolError),
    .miiLoopback(miiLoopback), .normalPower(normalPower), .rxBit(rxBit),
    .rxBitValid(rxBitValid), .txBit(txBit), .txBitValid(txBitValid),
    .prbsErrWrap(prbsErrWrap), .intOut(intOut));

//--- dv/rxb_mac_model.sv
// far-side model: loops generated bits back, can corrupt them
`timescale 1ns/10ps

module rxb_mac_model
(
    input  wire logic mclk,       // clock
    input  wire logic reset,      // sync reset
    input  wire logic txBit,      // bit from generator
    input  wire logic txBitValid, // generator qualifier
    input  wire logic flipBits,   // invert looped bits
    output logic      rxBit,      // bit to checker
    output logic      rxBitValid  // checker qualifier
);
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            rxBit      <= 1'b0;
            rxBitValid <= 1'b0;
        end
        else
        begin
            rxBitValid <= txBitValid;
            // idle line toggles so a stale bit is never mistaken for data
            rxBit      <= txBitValid ? (txBit ^ flipBits) : ~rxBit;
        end
    end
endmodule

//--- dv/testbench.sv
// self-checking bench for the receive error and self-test block
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: %h not %h", $time, (a), (b)); end end

module testbench;
    import rxb_pkg::*;
    localparam int PKT = 16;
    logic        mclk, reset, regWrite, regRead, rxDataValid, rxCarrier;
    logic        rxSymbolError, miiLoopback, normalPower, flipBits;
    logic        rxBit, rxBitValid, txBit, txBitValid, prbsErrWrap, intOut;
    logic [4:0]  regAddr;
    logic [15:0] regWrData, regRdData, d, d2;
    int          checks, n_mismatch, cycles, txCount;

    rxb_error_bist #(.PKT_BITS(PKT), .GAP_BITS(4), .LOCK_RUN(16), .LOSS_RUN(4))
    rxb_error_bist_inst (
        .mclk(mclk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .rxDataValid(rxDataValid), .rxCarrier(rxCarrier), .rxSymbolError(rxSymbolError),
        .miiLoopback(miiLoopback), .normalPower(normalPower), .rxBit(rxBit),
        .rxBitValid(rxBitValid), .txBit(txBit), .txBitValid(txBitValid),
        .prbsErrWrap(prbsErrWrap), .intOut(intOut));
    rxb_mac_model rxb_mac_model_inst (
        .mclk(mclk), .reset(reset), .txBit(txBit), .txBitValid(txBitValid),
        .flipBits(flipBits), .rxBit(rxBit), .rxBitValid(rxBitValid));

    initial
    begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // whole run including the long error burst is about 66k cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (txBitValid === 1'b1) txCount++;
        if (cycles == 90000)
        begin
            n_mismatch++;
            $display("wrong value at %0t: run hung", $time);
            close_out;
        end
    end

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge mclk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= v;
        @(posedge mclk);
        regWrite  <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 v = regRdData;
    endtask

    // two reads of the error count with no gap between the strobes
    task automatic rd2(output logic [15:0] v1, output logic [15:0] v2);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= ADDR_RX_ERR;
        @(posedge mclk);
        #1 v1 = regRdData;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 v2 = regRdData;
    endtask

    task automatic errs(input int n, input logic dv, input logic crs, input logic lb);
        @(posedge mclk);
        rxDataValid   <= dv;
        rxCarrier     <= crs;
        miiLoopback   <= lb;
        rxSymbolError <= 1'b1;
        repeat (n) @(posedge mclk);
        rxSymbolError <= 1'b0;
    endtask

    initial
    begin
        {regWrite, regRead, rxDataValid, rxCarrier, rxSymbolError} = '0;
        {miiLoopback, flipBits, regAddr, regWrData} = '0;
        {checks, n_mismatch, cycles, txCount} = '0;
        normalPower = 1'b1;
        reset = 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        rd(ADDR_SELF_TEST, d); `CHK(d, 16'h0100)
        rd(ADDR_RX_ERR, d); `CHK(d, RX_ERR_RST)
        rd(5'h03, d); `CHK(d, DATA_ZERO)
        wr(ADDR_SELF_TEST, 16'hffff);
        rd(ADDR_SELF_TEST, d); `CHK(d & 16'hf1ff, 16'h7100)
        wt(300);
        rd(ADDR_SELF_TEST, d); `CHK(d[STC_LOCK_BIT], 1'b1)
        `CHK(d[STC_GEN_STAT_BIT], 1'b1)
        `CHK(txCount > PKT, 1'b1)
        @(posedge mclk) flipBits <= 1'b1;
        repeat (20) @(posedge mclk);
        flipBits <= 1'b0;
        wt(300);
        rd(ADDR_SELF_TEST, d); `CHK(d[STC_LOSS_BIT], 1'b1)
        `CHK(d[STC_LOCK_BIT], 1'b1)
        rd(ADDR_SELF_TEST, d); `CHK(d[STC_LOSS_BIT], 1'b0)
        // only the misses seen while still locked count, loss hits on the fourth
        rd(ADDR_PRBS_ERR, d); `CHK(d, 16'h0004)
        wr(ADDR_SELF_TEST, 16'h0000);
        wt(10);
        txCount = 0;
        wt(30); `CHK(txCount, 0)
        wr(ADDR_SELF_TEST, 16'h1000);
        wt(100); `CHK(txCount, PKT)
        rd(ADDR_SELF_TEST, d); `CHK(d[STC_LOCK_BIT], 1'b0)
        wr(ADDR_SELF_TEST, 16'h0000);
        wt(5);
        rd(ADDR_SELF_TEST, d); `CHK(d[STC_GEN_STAT_BIT], 1'b0)
        @(posedge mclk) normalPower <= 1'b0;
        wt(3);
        rd(ADDR_SELF_TEST, d); `CHK(d[STC_POWER_BIT], 1'b0)
        @(posedge mclk) normalPower <= 1'b1;
        errs(5, 1'b1, 1'b1, 1'b1);
        rd(ADDR_RX_ERR, d); `CHK(d, 16'h0000)
        errs(5, 1'b1, 1'b0, 1'b0);
        rd(ADDR_RX_ERR, d); `CHK(d, 16'h0000)
        errs(5, 1'b0, 1'b1, 1'b0);
        rd(ADDR_RX_ERR, d); `CHK(d, 16'h0000)
        errs(3, 1'b1, 1'b1, 1'b0);
        rd(ADDR_RX_ERR, d); `CHK(d, 16'h0003)
        rd(ADDR_RX_ERR, d); `CHK(d, 16'h0000)
        wr(ADDR_PHY_CTRL, 16'h0003);
        wr(ADDR_INT_CTRL, 16'h0001);
        wt(3); `CHK(intOut, 1'b0)
        errs(65540, 1'b1, 1'b1, 1'b0);
        wt(3); `CHK(intOut, 1'b1)
        rd2(d, d2); `CHK(d, RX_ERR_MAX)
        `CHK(d2, 16'h0000)
        wr(ADDR_PHY_CTRL, 16'h0001);
        wt(3); `CHK(intOut, 1'b0)
        wr(ADDR_PHY_CTRL, 16'h0003);
        wt(3); `CHK(intOut, 1'b1)
        wr(ADDR_INT_CTRL, 16'h0000);
        wt(3); `CHK(intOut, 1'b0)
        wr(ADDR_INT_CTRL, 16'h0001);
        rd(ADDR_INT_CTRL, d); `CHK(d, 16'h0101)
        wt(3); `CHK(intOut, 1'b0)
        rd(ADDR_INT_CTRL, d); `CHK(d, 16'h0001)
        close_out;
    end
endmodule
